//--- logic/xdl_consts.svh
// constants for the xor and direction-load executor
// assumes 14-bit instruction words and 8-bit data
`ifndef XDL_CONSTS_SVH
`define XDL_CONSTS_SVH
// ==========================================
// encodings
`define XDL_DIR_LOAD_HI 11'h00C
`define XDL_XOR_LIT_HI 6'h3A
`define XDL_XOR_FILE_HI 6'h06
`define XDL_DIR_SEL_MIN 3'h5
`define XDL_DIR_SEL_MAX 3'h7
`define XDL_DIR_RESET 8'hFF
`define XDL_W_RESET 8'h00
`endif

//--- logic/xdl_pkg.sv
// types for the xor and direction-load executor
// assumes xdl_consts.svh is on the include path
`default_nettype none
package xdl_pkg;
	typedef logic [13:0] xdl_word_t;
	typedef logic [7:0] xdl_byte_t;
	typedef enum logic [1:0] {
		XDL_OP_NONE = 2'b00,
		XDL_OP_DIR = 2'b01,
		XDL_OP_XLIT = 2'b10,
		XDL_OP_XFILE = 2'b11
	} xdl_op_e;
	// file register port request
	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} xdl_file_wr_s;
endpackage : xdl_pkg
`default_nettype wire

//--- logic/xdl_decode.sv
// decoder for the three instruction forms
// assumes a valid fetched word from the same clock domain
`include "xdl_consts.svh"
`default_nettype none
module xdl_decode (
	input wire xdl_pkg::xdl_word_t insn,
	output xdl_pkg::xdl_op_e op
);
	import xdl_pkg::*;
	wire is_dir;
	wire is_xlit;
	wire is_xfile;
	// ==========================================
	// opcode match
	assign is_dir = (insn[13:3] == `XDL_DIR_LOAD_HI) &&
		(insn[2:0] >= `XDL_DIR_SEL_MIN) && (insn[2:0] <= `XDL_DIR_SEL_MAX);
	assign is_xlit = (insn[13:8] == `XDL_XOR_LIT_HI);
	assign is_xfile = (insn[13:8] == `XDL_XOR_FILE_HI);
	assign op = is_dir ? XDL_OP_DIR : is_xlit ? XDL_OP_XLIT :
		is_xfile ? XDL_OP_XFILE : XDL_OP_NONE;
endmodule : xdl_decode
`default_nettype wire

//--- logic/xdl_exec.sv
// executor for direction-load, xor literal and xor file instructions
// assumes a file array with combinational read and a one-cycle write port
`include "xdl_consts.svh"
`default_nettype none
module xdl_exec #(
	parameter int DIR_ADDR_BASE = 133
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic insn_valid,
	input wire xdl_pkg::xdl_word_t insn,
	input wire xdl_pkg::xdl_byte_t file_rd_data,
	input wire logic [7:0] dir_wr_addr,
	input wire logic dir_wr_en,
	input wire xdl_pkg::xdl_byte_t dir_wr_data,
	output logic [6:0] file_rd_addr,
	output xdl_pkg::xdl_file_wr_s file_wr,
	output xdl_pkg::xdl_byte_t w_out,
	output logic zero_flag,
	output logic zero_we,
	output logic [23:0] dir_regs
);
	import xdl_pkg::*;
	xdl_op_e op;
	xdl_byte_t w_q, w_d;
	xdl_byte_t dir_q [3];
	xdl_byte_t dir_d [3];
	xdl_byte_t xor_res;
	xdl_file_wr_s fw_q, fw_d;
	logic z_q, z_d, zwe_q, zwe_d;
	wire dest_file;
	wire [1:0] dir_idx;
	wire [1:0] bus_idx;
	wire bus_hit;

	function automatic logic is_zero(input xdl_byte_t v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	// ==========================================
	// decode
	xdl_decode u_dec (
		.insn(insn),
		.op(op)
	);

	assign dest_file = insn[7];
	assign file_rd_addr = insn[6:0];
	assign xor_res = w_q ^ ((op == XDL_OP_XLIT) ? insn[7:0] : file_rd_data);
	assign dir_idx = 2'(insn[2:0] - `XDL_DIR_SEL_MIN);
	assign bus_idx = 2'(dir_wr_addr - 8'(DIR_ADDR_BASE));
	assign bus_hit = dir_wr_en && (dir_wr_addr >= 8'(DIR_ADDR_BASE)) &&
		(dir_wr_addr < 8'(DIR_ADDR_BASE + 3));

	// ==========================================
	// next state
	always_comb begin
		w_d = w_q;
		z_d = z_q;
		zwe_d = 1'b0;
		fw_d = '0;
		for (int i = 0; i < 3; i++) begin
			dir_d[i] = dir_q[i];
		end
		if (bus_hit) begin
			dir_d[bus_idx] = dir_wr_data;
		end
		if (insn_valid) begin
			unique case (op)
				XDL_OP_DIR: dir_d[dir_idx] = w_q;
				XDL_OP_XLIT: begin
					w_d = xor_res;
					z_d = is_zero(xor_res);
					zwe_d = 1'b1;
				end
				XDL_OP_XFILE: begin
					z_d = is_zero(xor_res);
					zwe_d = 1'b1;
					if (dest_file) begin
						fw_d = '{we: 1'b1, addr: insn[6:0], data: xor_res};
					end else begin
						w_d = xor_res;
					end
				end
				XDL_OP_NONE: ;
			endcase
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			w_q <= `XDL_W_RESET;
			z_q <= 1'b0;
			zwe_q <= 1'b0;
			fw_q <= '0;
			for (int i = 0; i < 3; i++) begin
				dir_q[i] <= `XDL_DIR_RESET;
			end
		end else begin
			w_q <= w_d;
			z_q <= z_d;
			zwe_q <= zwe_d;
			fw_q <= fw_d;
			for (int i = 0; i < 3; i++) begin
				dir_q[i] <= dir_d[i];
			end
		end
	end

	assign w_out = w_q;
	assign zero_flag = z_q;
	assign zero_we = zwe_q;
	assign file_wr = fw_q;
	assign dir_regs = {dir_q[2], dir_q[1], dir_q[0]};

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	xlit_result_a: assert property (insn_valid && op == XDL_OP_XLIT |=>
		w_out == ($past(w_q) ^ $past(insn[7:0]))) else $error("xor literal result wrong");
	xlit_nofile_a: assert property (insn_valid && op == XDL_OP_XLIT |=>
		!file_wr.we && zero_we) else $error("xor literal touched file");
	xfile_w_a: assert property (insn_valid && op == XDL_OP_XFILE && !insn[7] |=>
		w_out == ($past(w_q) ^ $past(file_rd_data)) && !file_wr.we)
		else $error("xor file to w wrong");
	xfile_f_a: assert property (insn_valid && op == XDL_OP_XFILE && insn[7] |=>
		file_wr.we && file_wr.data == ($past(w_q) ^ $past(file_rd_data)) &&
		file_wr.addr == $past(insn[6:0]) && $stable(w_out)) else $error("xor file to f wrong");
	zero_flag_a: assert property (zero_we |-> zero_flag == (w_out == 8'h00 && !file_wr.we ||
		file_wr.we && file_wr.data == 8'h00)) else $error("zero flag wrong");
	dir_load_a: assert property (insn_valid && op == XDL_OP_DIR && !bus_hit |=>
		dir_q[$past(dir_idx)] == $past(w_q) && !zero_we && $stable(zero_flag))
		else $error("direction load wrong");
	dir_bus_a: assert property (bus_hit && !(insn_valid && op == XDL_OP_DIR) |=>
		dir_q[$past(bus_idx)] == $past(dir_wr_data)) else $error("direction write wrong");
	idle_hold_a: assert property (!insn_valid |=> $stable(w_out) && !file_wr.we && !zero_we)
		else $error("idle changed state");


	// ==========================================
	// refused words, flags and sources of change
	none_hold_a: assert property (insn_valid && op == XDL_OP_NONE |=>
		$stable(w_out) && !file_wr.we && !zero_we && $stable(zero_flag))
		else $error("refused word changed state");
	dir_keep_a: assert property (insn_valid && op == XDL_OP_DIR |=>
		$stable(w_out) && !file_wr.we)
		else $error("direction load touched w or file");
	dir_wins_a: assert property (insn_valid && op == XDL_OP_DIR && bus_hit &&
		bus_idx == dir_idx |=> dir_q[$past(dir_idx)] == $past(w_q))
		else $error("direction load lost to file write");
	dir_still_a: assert property (!(insn_valid && op == XDL_OP_DIR) && !bus_hit |=>
		$stable(dir_regs))
		else $error("direction register changed without cause");
	zero_hold_a: assert property (!zero_we |-> $stable(zero_flag))
		else $error("zero flag changed without update");
	xlit_zero_a: assert property (insn_valid && op == XDL_OP_XLIT |=>
		zero_flag == (($past(w_q) ^ $past(insn[7:0])) == 8'h00))
		else $error("xor literal zero flag wrong");
	xfile_zero_a: assert property (insn_valid && op == XDL_OP_XFILE |=>
		zero_flag == (($past(w_q) ^ $past(file_rd_data)) == 8'h00))
		else $error("xor file zero flag wrong");
	fwe_source_a: assert property (file_wr.we |->
		$past(insn_valid && op == XDL_OP_XFILE && insn[7]))
		else $error("file write without xor file to f");
	zwe_source_a: assert property (zero_we |->
		$past(insn_valid && (op == XDL_OP_XLIT || op == XDL_OP_XFILE)))
		else $error("zero update without xor");
	w_source_a: assert property ($changed(w_out) |-> $past(insn_valid) &&
		($past(op) == XDL_OP_XLIT || ($past(op) == XDL_OP_XFILE && !$past(insn[7]))))
		else $error("w changed without xor to w");
	xfile_addr_a: assert property (insn_valid && op == XDL_OP_XFILE && insn[7] |=>
		file_wr.addr == $past(file_rd_addr))
		else $error("xor file wrote other address");
	reset_vals_a: assert property (disable iff (1'b0) reset |=>
		w_out == `XDL_W_RESET && !zero_flag && !zero_we && !file_wr.we &&
		dir_regs == {3{`XDL_DIR_RESET}})
		else $error("reset values wrong");

	// ==========================================
	// covers
	xlit_c: cover property (insn_valid && op == XDL_OP_XLIT ##1 zero_flag);
	xfile_c: cover property (insn_valid && op == XDL_OP_XFILE && insn[7]);
	dir_c: cover property (insn_valid && op == XDL_OP_DIR);
	xfile_w_c: cover property (insn_valid && op == XDL_OP_XFILE && !insn[7]);
	bus_c: cover property (bus_hit);
endmodule : xdl_exec
`default_nettype wire

//--- bench/xdl_testbench.sv
// bench for the xor and direction-load executor
// assumes xdl_pkg is compiled first; bench drives every input port
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import xdl_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic insn_valid = 1'b0;
	xdl_word_t insn = 14'h0000;
	xdl_byte_t file_rd_data = 8'h00;
	logic [7:0] dir_wr_addr = 8'h00;
	logic dir_wr_en = 1'b0;
	xdl_byte_t dir_wr_data = 8'h00;
	logic [6:0] file_rd_addr;
	xdl_file_wr_s file_wr;
	xdl_byte_t w_out;
	logic zero_flag;
	logic zero_we;
	logic [23:0] dir_regs;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	xdl_exec xdl_exec_i (.ref_clk(ref_clk), .reset(reset), .insn_valid(insn_valid),
		.insn(insn), .file_rd_data(file_rd_data), .dir_wr_addr(dir_wr_addr),
		.dir_wr_en(dir_wr_en), .dir_wr_data(dir_wr_data), .file_rd_addr(file_rd_addr),
		.file_wr(file_wr), .w_out(w_out), .zero_flag(zero_flag), .zero_we(zero_we),
		.dir_regs(dir_regs));
	// ==========
	// helpers
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	// one instruction, outputs checked after the answering edge
	task automatic run(input xdl_word_t word, input xdl_byte_t rd);
		@(posedge ref_clk);
		insn <= word;
		file_rd_data <= rd;
		insn_valid <= 1'b1;
		@(posedge ref_clk);
		insn_valid <= 1'b0;
		#1;
	endtask : run
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			print_verdict();
		end
	end
	// ==========
	// scenarios
	task automatic t_lit();
		run(14'h3AB5, 8'h00);
		run(14'h3AAF, 8'h00);
		check("w", w_out, 8'h1A);
		check("zwe", zero_we, 1'b1);
		check("z", zero_flag, 1'b0);
		check("fwe", file_wr.we, 1'b0);
		run(14'h3A1A, 8'h00);
		check("z", zero_flag, 1'b1);
		run(14'h3AFF, 8'h00);
		check("w", w_out, 8'hFF);
		run(14'h3F00, 8'h00);
		check("w", w_out, 8'hFF);
		check("zwe", zero_we, 1'b0);
		$display("lit test done");
	endtask : t_lit
	task automatic t_file();
		run(14'h06FF, 8'h5A);
		check("fra", file_rd_addr, 7'h7F);
		check("fw", file_wr, 16'hFFA5);
		check("w", w_out, 8'hFF);
		run(14'h0600, 8'hFF);
		check("w", w_out, 8'h00);
		check("fwe", file_wr.we, 1'b0);
		check("z", zero_flag, 1'b1);
		$display("file test done");
	endtask : t_file
	task automatic t_dir();
		run(14'h3A3C, 8'h00);
		run(14'h0065, 8'h00);
		run(14'h0067, 8'h00);
		run(14'h0064, 8'h00);
		check("dir", dir_regs, 24'h3CFF3C);
		check("zwe", zero_we, 1'b0);
		check("z", zero_flag, 1'b0);
		@(posedge ref_clk);
		dir_wr_addr <= 8'h86;
		dir_wr_data <= 8'hC3;
		dir_wr_en <= 1'b1;
		@(posedge ref_clk);
		dir_wr_en <= 1'b0;
		@(posedge ref_clk);
		#1;
		check("dir", dir_regs, 24'h3CC33C);
		$display("dir test done");
	endtask : t_dir
	// two literal xors on consecutive edges
	task automatic t_b2b();
		@(posedge ref_clk);
		insn <= 14'h3A0F;
		insn_valid <= 1'b1;
		@(posedge ref_clk);
		insn <= 14'h3AF0;
		@(posedge ref_clk);
		insn_valid <= 1'b0;
		#1;
		check("w", w_out, 8'hC3);
		check("z", zero_flag, 1'b0);
		$display("b2b test done");
	endtask : t_b2b
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		#1;
		check("w", w_out, 8'h00);
		check("dir", dir_regs, 24'hFFFFFF);
		check("z", zero_flag, 1'b0);
		check("zwe", zero_we, 1'b0);
		check("fw", file_wr, 16'h0000);
		$display("reset test done");
		t_lit();
		t_file();
		t_dir();
		t_b2b();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
